// [inc/gtw_defines.vh]
// Purpose: constants for the gain trim and wake timer register bank
// Assumes: 20 MHz MCLK, byte-wide register port
`ifndef GTW_DEFINES_VH
`define GTW_DEFINES_VH

`define GTW_ADDR_X_TRIM   8'h36
`define GTW_ADDR_Y_TRIM   8'h37
`define GTW_ADDR_Z_TRIM   8'h38
`define GTW_ADDR_TMR_CTRL 8'h39
`define GTW_ADDR_MAP_A    8'h3A
`define GTW_ADDR_MAP_B    8'h3B
`define GTW_ADDR_SECOND_STATUS_REG  8'h3E
`define GTW_ADDR_IRQ_MASK 8'h3F

`define GTW_RST_TRIM      6'h00
`define GTW_RST_CTRL      8'h00
`define GTW_RST_MAP       1'b0
`define GTW_RST_MASK      1'b0

`define GTW_TRIM_MSB      5
`define GTW_TRIM_W        6
`define GTW_WAKE_MSB      7
`define GTW_WAKE_LSB      6
`define GTW_KA_MSB        4
`define GTW_KA_LSB        0
`define GTW_KA_STAT_BIT   4
`define GTW_KA_MAP_BIT    4
`define GTW_KA_MAX_CODE   5'h14
`define GTW_KA_CNT_W      21
`define GTW_GAIN_SHIFT    6

`define GTW_CLK_HZ        20000000
`define GTW_TICK_MS       80
`define GTW_TICK_CYC      ((`GTW_TICK_MS * `GTW_CLK_HZ) / 1000)

`endif

// [logic/gtw_gain_apply.v]
// Purpose: one axis sensitivity trim, factory plus user, 1/64 per step
// Assumes: samples are signed two's complement
// Notes: result saturates to the sample width
`timescale 1ns/10ps
`include "gtw_defines.vh"
module gtw_gain_apply #(
  parameter W = 14
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] sample_in,
  input  wire [5:0]   factory_trim,
  input  wire [5:0]   user_trim,
  output wire [W-1:0] sample_out
);
  reg  [W-1:0]        out_ff;
  wire signed [6:0]   trim_sum;
  reg  signed [5:0]   trim_clamp;
  wire signed [W+5:0] prod;
  wire signed [W+5:0] delta;
  wire signed [W:0]   total;
  reg  [W-1:0]        nxt_out;

  // combined trim clamps to the shared headroom
  assign trim_sum = {factory_trim[5], factory_trim} + {user_trim[5], user_trim};
  always @* begin
    if (trim_sum > 7'sd31) begin
      trim_clamp = 6'sd31;
    end else if (trim_sum < -7'sd32) begin
      trim_clamp = 6'sh20;
    end else begin
      trim_clamp = trim_sum[5:0];
    end
  end

  // one step is 1/64 of the sample
  assign prod  = $signed(sample_in) * trim_clamp;
  assign delta = prod >>> `GTW_GAIN_SHIFT;
  assign total = $signed({sample_in[W-1], sample_in}) + delta[W:0];

  always @* begin
    if (total[W] != total[W-1]) begin
      nxt_out = total[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    end else begin
      nxt_out = total[W-1:0];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= {W{1'b0}};
    end else if (ce) begin
      out_ff <= nxt_out;
    end
  end

  assign sample_out = out_ff;
endmodule

// [logic/gtw_trim_timer.v]
// Purpose: gain trim registers, wake interval timer, keep-alive timer
// Assumes: single clock, host port with read data one cycle after strobe
// Notes: all state frozen while CE is low
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "gtw_defines.vh"
module gtw_trim_timer #(
  parameter W        = 14,
  parameter TICK_CYC = `GTW_TICK_CYC
) (
  input  wire           MCLK,
  input  wire           RSTN,
  input  wire           CE,
  input  wire [7:0]     ADDR,
  input  wire [7:0]     WDATA,
  input  wire           WR,
  input  wire           RD,
  output wire [7:0]     RDATA,
  input  wire [3*W-1:0] AXIS_IN,
  input  wire [17:0]    FACTORY_TRIM,
  output wire [3*W-1:0] AXIS_OUT,
  output wire           WAKE_SAMPLE,
  output wire           IRQ_PIN_A,
  output wire           IRQ_PIN_B,
  output wire           IRQ
);
  localparam [`GTW_KA_CNT_W-1:0] KA_ONE   = {{(`GTW_KA_CNT_W-1){1'b0}}, 1'b1};
  localparam [3:0]               WK_ONE   = 4'h1;
  localparam [31:0]              TICK_MAX = TICK_CYC - 1;

  // register state
  reg  [5:0]  x_gain_trim_value_ff;
  reg  [5:0]  y_gain_trim_value_ff;
  reg  [5:0]  z_gain_trim_value_ff;
  reg  [7:0]  tmr_ctrl_ff;
  reg         keepalive_route_pin_a_ff;
  reg         keepalive_route_pin_b_ff;
  reg         ka_status_ff;
  reg         ka_mask_ff;
  reg  [7:0]  rdata_ff;
  reg  [7:0]  nxt_rdata;

  // timer state
  reg  [31:0]               wk_pre_ff;
  reg  [3:0]                wk_cnt_ff;
  reg                       wake_ff;
  reg  [31:0]               ka_pre_ff;
  reg  [`GTW_KA_CNT_W-1:0]  ka_cnt_ff;
  reg                       ka_expire_ff;

  wire        wr_x;
  wire        wr_y;
  wire        wr_z;
  wire        wr_ctrl;
  wire        wr_map_a;
  wire        wr_map_b;
  wire        wr_mask;
  wire        rd_status;
  wire [1:0]  wake_sample_interval;
  wire [4:0]  ka_code;
  wire        ka_run;
  wire        wk_tick;
  wire        ka_tick;
  wire [3:0]  wk_target;
  wire [`GTW_KA_CNT_W-1:0] ka_target;
  wire [17:0] user_trim_bus;

  // address decode
  assign wr_x      = CE & WR & (ADDR == `GTW_ADDR_X_TRIM);
  assign wr_y      = CE & WR & (ADDR == `GTW_ADDR_Y_TRIM);
  assign wr_z      = CE & WR & (ADDR == `GTW_ADDR_Z_TRIM);
  assign wr_ctrl   = CE & WR & (ADDR == `GTW_ADDR_TMR_CTRL);
  assign wr_map_a  = CE & WR & (ADDR == `GTW_ADDR_MAP_A);
  assign wr_map_b  = CE & WR & (ADDR == `GTW_ADDR_MAP_B);
  assign wr_mask   = CE & WR & (ADDR == `GTW_ADDR_IRQ_MASK);
  assign rd_status = CE & RD & (ADDR == `GTW_ADDR_SECOND_STATUS_REG);

  // control fields
  assign wake_sample_interval = tmr_ctrl_ff[`GTW_WAKE_MSB:`GTW_WAKE_LSB];
  assign ka_code = tmr_ctrl_ff[`GTW_KA_MSB:`GTW_KA_LSB];
  // zero and codes above the largest keep the timer stopped
  assign ka_run  = (ka_code != 5'h00) && (ka_code <= `GTW_KA_MAX_CODE);

  // trim registers
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      x_gain_trim_value_ff <= `GTW_RST_TRIM;
      y_gain_trim_value_ff <= `GTW_RST_TRIM;
      z_gain_trim_value_ff <= `GTW_RST_TRIM;
    end else begin
      if (wr_x) begin
        x_gain_trim_value_ff <= WDATA[`GTW_TRIM_MSB:0];
      end
      if (wr_y) begin
        y_gain_trim_value_ff <= WDATA[`GTW_TRIM_MSB:0];
      end
      if (wr_z) begin
        z_gain_trim_value_ff <= WDATA[`GTW_TRIM_MSB:0];
      end
    end
  end

  // timer control, map and mask registers
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tmr_ctrl_ff              <= `GTW_RST_CTRL;
      keepalive_route_pin_a_ff <= `GTW_RST_MAP;
      keepalive_route_pin_b_ff <= `GTW_RST_MAP;
      ka_mask_ff               <= `GTW_RST_MASK;
    end else begin
      if (wr_ctrl) begin
        tmr_ctrl_ff <= WDATA;
      end
      if (wr_map_a) begin
        keepalive_route_pin_a_ff <= WDATA[`GTW_KA_MAP_BIT];
      end
      if (wr_map_b) begin
        keepalive_route_pin_b_ff <= WDATA[`GTW_KA_MAP_BIT];
      end
      if (wr_mask) begin
        ka_mask_ff <= WDATA[`GTW_KA_STAT_BIT];
      end
    end
  end

  // wake interval: 80 ms tick, 1, 2, 4 or 8 ticks
  assign wk_tick   = (wk_pre_ff == TICK_MAX);
  assign wk_target = WK_ONE << wake_sample_interval;

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      wk_pre_ff <= 32'h0;
      wk_cnt_ff <= 4'h0;
      wake_ff   <= 1'b0;
    end else if (CE) begin
      wake_ff <= 1'b0;
      if (wk_tick) begin
        wk_pre_ff <= 32'h0;
        if (wk_cnt_ff >= wk_target - WK_ONE) begin
          wk_cnt_ff <= 4'h0;
          wake_ff   <= 1'b1;
        end else begin
          wk_cnt_ff <= wk_cnt_ff + WK_ONE;
        end
      end else begin
        wk_pre_ff <= wk_pre_ff + 32'h1;
      end
    end
  end

  // keep-alive: period is 2^code ticks of 80 ms
  assign ka_tick   = (ka_pre_ff == TICK_MAX);
  assign ka_target = KA_ONE << ka_code;

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ka_pre_ff    <= 32'h0;
      ka_cnt_ff    <= {`GTW_KA_CNT_W{1'b0}};
      ka_expire_ff <= 1'b0;
    end else if (CE) begin
      ka_expire_ff <= 1'b0;
      if (wr_ctrl || !ka_run) begin
        // restart from zero on any timer control register write or while stopped
        ka_pre_ff <= 32'h0;
        ka_cnt_ff <= {`GTW_KA_CNT_W{1'b0}};
      end else if (ka_tick) begin
        ka_pre_ff <= 32'h0;
        if (ka_cnt_ff == ka_target - KA_ONE) begin
          ka_cnt_ff    <= {`GTW_KA_CNT_W{1'b0}};
          ka_expire_ff <= 1'b1;
        end else begin
          ka_cnt_ff <= ka_cnt_ff + KA_ONE;
        end
      end else begin
        ka_pre_ff <= ka_pre_ff + 32'h1;
      end
    end
  end

  // expiry flag: set wins over clear-on-read
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ka_status_ff <= 1'b0;
    end else if (CE) begin
      if (ka_expire_ff) begin
        ka_status_ff <= 1'b1;
      end else if (rd_status) begin
        ka_status_ff <= 1'b0;
      end
    end
  end

  // read mux
  always @* begin
    nxt_rdata = 8'h00;
    case (ADDR)
      `GTW_ADDR_X_TRIM:   nxt_rdata = {2'b00, x_gain_trim_value_ff};
      `GTW_ADDR_Y_TRIM:   nxt_rdata = {2'b00, y_gain_trim_value_ff};
      `GTW_ADDR_Z_TRIM:   nxt_rdata = {2'b00, z_gain_trim_value_ff};
      `GTW_ADDR_TMR_CTRL: nxt_rdata = tmr_ctrl_ff;
      `GTW_ADDR_MAP_A:    nxt_rdata = {3'b000, keepalive_route_pin_a_ff, 4'h0};
      `GTW_ADDR_MAP_B:    nxt_rdata = {3'b000, keepalive_route_pin_b_ff, 4'h0};
      `GTW_ADDR_SECOND_STATUS_REG:  nxt_rdata = {3'b000, ka_status_ff, 4'h0};
      `GTW_ADDR_IRQ_MASK: nxt_rdata = {3'b000, ka_mask_ff, 4'h0};
      default:            nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= 8'h00;
    end else if (CE) begin
      rdata_ff <= RD ? nxt_rdata : 8'h00;
    end
  end

  // per-axis gain datapath
  assign user_trim_bus = {z_gain_trim_value_ff, y_gain_trim_value_ff, x_gain_trim_value_ff};

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
      gtw_gain_apply #(
        .W (W)
      ) u_gain (
        .clk          (MCLK),
        .rst_n        (RSTN),
        .ce           (CE),
        .sample_in    (AXIS_IN[ax*W +: W]),
        .factory_trim (FACTORY_TRIM[ax*6 +: 6]),
        .user_trim    (user_trim_bus[ax*6 +: 6]),
        .sample_out   (AXIS_OUT[ax*W +: W])
      );
    end
  endgenerate

  assign RDATA       = rdata_ff;
  assign WAKE_SAMPLE = wake_ff;
  assign IRQ_PIN_A   = ka_status_ff & keepalive_route_pin_a_ff;
  assign IRQ_PIN_B   = ka_status_ff & keepalive_route_pin_b_ff;
  assign IRQ         = ka_status_ff & ka_mask_ff;
endmodule

// [tb/gtw_trim_timer_monitor.sv]
// Purpose: port checker for the trim and wake timer bank
// Assumes: one clock, TICK_CYC as in the design
// Notes: map, mask and code shadows rebuilt from writes
`timescale 1ns/10ps
module gtw_mon #(
  parameter TICK_CYC = 4
) (
  input wire       MCLK,
  input wire       RSTN,
  input wire       CE,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       WAKE_SAMPLE,
  input wire       IRQ_PIN_A,
  input wire       IRQ_PIN_B,
  input wire       IRQ
);
  reg        map_a_ff;
  reg        map_b_ff;
  reg        mask_ff;
  reg [4:0]  code_ff;
  reg [31:0] cnt_ff;
  wire       wr_ok = WR && CE;
  wire       st_rd = RD && CE && ADDR == 8'h3E;
  wire       ka_off = code_ff == 5'h00 || code_ff > 5'h14;
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      map_a_ff <= 1'b0;
      map_b_ff <= 1'b0;
      mask_ff <= 1'b0;
      code_ff <= 5'h00;
      cnt_ff <= 32'h0;
    end else if (CE) begin
      cnt_ff <= (wr_ok && ADDR == 8'h39) ? 32'h0 : cnt_ff + 32'h1;
      if (wr_ok && ADDR == 8'h3A) map_a_ff <= WDATA[4];
      if (wr_ok && ADDR == 8'h3B) map_b_ff <= WDATA[4];
      if (wr_ok && ADDR == 8'h3F) mask_ff <= WDATA[4];
      if (wr_ok && ADDR == 8'h39) code_ff <= WDATA[4:0];
    end
  end
  default clocking dc @(posedge MCLK); endclocking
  default disable iff (!RSTN || !CE);
  property p_trim_rsv;
    RD && CE && ADDR inside {8'h36, 8'h37, 8'h38} |=> RDATA[7:6] == 2'b00;
  endproperty
  a_trim_rsv: assert property (p_trim_rsv) else $error("trim reserved bits set");
  property p_wake;
    WAKE_SAMPLE |=> !WAKE_SAMPLE [*3];
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse too close");
  property p_ka_off;
    ka_off && !IRQ_PIN_A && !WR && !$past(WR) |=> !IRQ_PIN_A;
  endproperty
  a_ka_off: assert property (p_ka_off) else $error("expiry while timer off");
  property p_ka_time;
    $rose(IRQ_PIN_A) && !$past(WR) && !ka_off |-> (cnt_ff - 32'h1) % (TICK_CYC << code_ff) == 0;
  endproperty
  a_ka_time: assert property (p_ka_time) else $error("expiry off period");
  property p_stat;
    st_rd && IRQ_PIN_A |=> RDATA == 8'h10;
  endproperty
  a_stat: assert property (p_stat) else $error("status bit missing");
  property p_clr;
    st_rd && ka_off && !$past(WR) |=> !IRQ_PIN_A;
  endproperty
  a_clr: assert property (p_clr) else $error("status not cleared");
  property p_pin_b;
    IRQ_PIN_A && map_b_ff |-> IRQ_PIN_B;
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b not routed");
  property p_mask;
    IRQ |-> mask_ff;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt");
  property p_route;
    !map_a_ff |-> !IRQ_PIN_A;
  endproperty
  a_route: assert property (p_route) else $error("pin a not mapped");
  cover property (st_rd && IRQ_PIN_A);
  cover property ($rose(IRQ_PIN_A));
  cover property (WAKE_SAMPLE);
endmodule
bind gtw_trim_timer gtw_mon #(.TICK_CYC(TICK_CYC)) u_mon (.MCLK(MCLK), .RSTN(RSTN), .CE(CE),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .WAKE_SAMPLE(WAKE_SAMPLE),
  .IRQ_PIN_A(IRQ_PIN_A), .IRQ_PIN_B(IRQ_PIN_B), .IRQ(IRQ));

// [tb/test_gain_trim_and_wake_timer.sv]
// Purpose: self-checking bench for the trim and wake timer bank
// Assumes: TICK_CYC shortened to 4 cycles
// Notes: host strobes move right after MCLK rise
`timescale 1ns/10ps
module test_gain_trim_and_wake_timer;
  localparam TK = 4;
  logic        mclk;
  logic        rstn;
  logic        ce;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [41:0] ax_in;
  logic [41:0] ax_out;
  logic [17:0] ftrim;
  logic        wake;
  logic        pin_a;
  logic        pin_b;
  logic        irq;
  int          miscompares;
  int          comparisons;
  always #25 mclk = ~mclk;
  gtw_trim_timer #(.W(14), .TICK_CYC(TK)) dut (
    .MCLK(mclk), .RSTN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .AXIS_IN(ax_in), .FACTORY_TRIM(ftrim), .AXIS_OUT(ax_out),
    .WAKE_SAMPLE(wake), .IRQ_PIN_A(pin_a), .IRQ_PIN_B(pin_b), .IRQ(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic waitpin(input int lim, input bit hit, output int n);
    #1 n = 0;
    while (pin_a !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    if (hit && pin_a !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic waitwake(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (wake !== 1'b1 && n < 64);
    if (wake !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask
  task automatic t_reset;
    logic [7:0] regs [8] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3E, 8'h3F};
    foreach (regs[i]) rchk(regs[i], 8'h00);
  endtask
  task automatic t_trim;
    for (int a = 'h36; a <= 'h38; a++) begin
      wreg(a[7:0], 8'hFF);
      rchk(a[7:0], 8'h3F);
    end
    wreg(8'h40, 8'h5A);
    rchk(8'h40, 8'h00);
  endtask
  task automatic t_gain;
    wreg(8'h36, 8'h01);
    wreg(8'h37, 8'h20);
    wreg(8'h38, 8'h1F);
    repeat (2) @(posedge mclk);
    #1 chk({2'b00, ax_out[13:0]}, 16'd650);
    chk({2'b00, ax_out[27:14]}, 16'd320);
    chk({2'b00, ax_out[41:28]}, 16'd950);
  endtask
  task automatic t_ce;
    @(posedge mclk);
    ce <= 1'b0;
    wreg(8'h36, 8'h05);
    @(posedge mclk);
    ce <= 1'b1;
    rchk(8'h36, 8'h01);
  endtask
  task automatic t_wake;
    int n;
    for (int r = 0; r < 4; r++) begin
      wreg(8'h39, {r[1:0], 6'h00});
      rchk(8'h39, {r[1:0], 6'h00});
      repeat (3) waitwake(n);
      chk(n[15:0], 16'(TK << r));
    end
  endtask
  task automatic t_ka;
    int n;
    logic [7:0] d;
    wreg(8'h3A, 8'h10);
    wreg(8'h3B, 8'h10);
    wreg(8'h3F, 8'h10);
    for (int c = 1; c < 13; c = (c == 3) ? 12 : c + 1) begin
      wreg(8'h39, 8'h00);
      rreg(8'h3E, d);
      wreg(8'h39, {3'h0, c[4:0]});
      waitpin((TK << c) + 8, 1'b1, n);
      chk(n[15:0], 16'((TK << c) + 1));
      chk({14'h0, pin_b, irq}, 16'h3);
      rchk(8'h3E, 8'h10);
      chk({15'h0, pin_a}, 16'h0);
    end
    wreg(8'h39, 8'h02);
    repeat (10) @(posedge mclk);
    wreg(8'h39, 8'h02);
    waitpin(40, 1'b1, n);
    chk(n[15:0], 16'(4 * TK + 1));
    wreg(8'h3F, 8'h00);
    #1 chk({14'h0, pin_a, irq}, 16'h2);
    wreg(8'h3A, 8'h00);
    #1 chk({14'h0, pin_a, pin_b}, 16'h1);
    wreg(8'h3A, 8'h10);
    for (int k = 0; k < 2; k++) begin
      wreg(8'h39, k ? 8'h15 : 8'h00);
      rreg(8'h3E, d);
      waitpin(100, 1'b0, n);
      chk(n[15:0], 16'd100);
    end
  endtask
  task automatic test_done;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ax_in = {3{14'd640}};
    ftrim = 18'h01000;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_trim();
    t_gain();
    t_ce();
    t_wake();
    t_ka();
    test_done();
  end
endmodule
